// file: hw/tso_ctrl.sv
// Capacitive touch oscillator control and counting logic
//
// Overview of operation
// - Enable bit 7 turns the module on, and the oscillator unless fixed range 00; zero turns it off.
// - Bit 6 one picks variable external thresholds; zero picks fixed ones.
// - Bits 3 to 2 hold a two-bit range field, four ranges per mode.
// - Variable mode: 11 high, 10 medium, 01 low, 00 noise detection.
// - Fixed mode: 00 oscillator off, 01 low, 10 medium, 11 high.
// - Noise detection drops only the current source, comparators stay on.
// - Direction status reads one while sourcing, zero while sinking.
// - Three-bit channel picks one of eight inputs only while enabled.
// - Clock select bit 0, with wide register bit 2 set, routes the oscillator to the 8-bit timer.
// - Wide timer source 11 clocks the 16-bit timer from the oscillator.
// - Wide timer off when on bit 0; gate enable restricts counting.
// - Oscillator keeps running in sleep while enabled; wide timer counts.
// - The 8-bit timer does not count during sleep.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none
module tso_ctrl
    import tso_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Core state and outside timer signals
    input  wire logic        sleep_i,
    input  wire logic        wide_gate_i,
    // Analog oscillator front end
    input  wire logic        osc_level_i,
    output logic             osc_enable_o,
    output logic             current_source_en_o,
    output logic             comparator_en_o,
    output logic             variable_ref_o,
    output logic      [1:0]  current_level_o,
    output logic      [7:0]  sense_input_pin_sel_o,
    // Counting clocks to the timers
    output logic             eight_bit_count_en_o,
    output logic             wide_count_en_o
);

    initial begin
        if (CHANNELS != 8) begin
            $error("tso_ctrl supports exactly eight sense inputs");
        end
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] chan;
        logic [7:0] wide;
        logic [7:0] count8;
        logic       sync1;
        logic       sync2;
        logic       sync3;
        logic [7:0] rdata;
        logic       osc_en;
        logic       src_en;
        logic       cmp_en;
        logic       vref;
        logic [1:0] level;
        logic [7:0] pin_sel;
        logic       en8;
        logic       enw;
    } tso_state_t;

    tso_state_t r;
    tso_state_t next_r;

    function automatic tso_osc_mode_t osc_mode(input logic en,
                                               input logic vmode,
                                               input logic [1:0] rng);
        tso_osc_mode_t m;
        m = TSO_OSC_OFF;
        if (en) begin
            case (rng)
                TSO_RANGE_OFF: begin
                    m = vmode ? TSO_OSC_NOISE : TSO_OSC_OFF;
                end
                TSO_RANGE_LOW:  m = TSO_OSC_LOW;
                TSO_RANGE_MED:  m = TSO_OSC_MED;
                TSO_RANGE_HIGH: m = TSO_OSC_HIGH;
                default:        m = TSO_OSC_OFF;
            endcase
        end
        return m;
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] mask);
        return (old & ~mask) | (wd & mask);
    endfunction

    // Oscillator powered for this enable, reference mode and range
    function automatic logic osc_runs(input logic       en,
                                      input logic       vmode,
                                      input logic [1:0] rng);
        return en && (vmode || (rng != TSO_RANGE_OFF));
    endfunction

    // Wide timer clock source field points at the oscillator
    function automatic logic wide_from_osc(input logic [7:0] w);
        return w[TSO_BIT_WSRC_HI:TSO_BIT_WSRC_LO] == TSO_WSRC_OSC;
    endfunction

    tso_osc_mode_t mode;
    logic          osc_edge;
    logic          wide_on;
    logic          wide_gated;

    always_comb begin
        next_r = r;
        mode = osc_mode(r.ctrl[TSO_BIT_ENABLE], r.ctrl[TSO_BIT_REFMODE],
                        r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO]);
        // Oscillator level passes two flops before use
        next_r.sync1 = osc_level_i;
        next_r.sync2 = r.sync1;
        next_r.sync3 = r.sync2;
        osc_edge = r.sync2 & ~r.sync3;
        // Status bit tracks direction; oscillator off reads sinking
        next_r.ctrl[TSO_BIT_DIR] = (mode != TSO_OSC_OFF) & r.sync2;
        // Front end controls; sleep does not stop the oscillator
        next_r.osc_en = (mode != TSO_OSC_OFF);
        next_r.cmp_en = (mode != TSO_OSC_OFF);
        next_r.src_en = (mode != TSO_OSC_OFF) && (mode != TSO_OSC_NOISE);
        next_r.vref = r.ctrl[TSO_BIT_REFMODE];
        case (mode)
            TSO_OSC_LOW:  next_r.level = TSO_RANGE_LOW;
            TSO_OSC_MED:  next_r.level = TSO_RANGE_MED;
            TSO_OSC_HIGH: next_r.level = TSO_RANGE_HIGH;
            default:      next_r.level = TSO_RANGE_OFF;
        endcase
        next_r.pin_sel = r.ctrl[TSO_BIT_ENABLE] ?
                         (8'h01 << r.chan) : 8'h00;
        // 8-bit timer counts oscillator edges, never in sleep
        next_r.en8 = osc_edge & r.ctrl[TSO_BIT_TIMER_ZERO_EXTERNAL_CLOCK_SELECT] &
                     r.wide[TSO_BIT_W8CS] & ~sleep_i;
        wide_on = r.wide[TSO_BIT_WON];
        wide_gated = ~r.wide[TSO_BIT_WGE] | wide_gate_i;
        next_r.enw = osc_edge & wide_on & wide_gated &
                     wide_from_osc(r.wide);
        if (next_r.en8) begin
            next_r.count8 = r.count8 + 8'h01;
        end
        // Register writes; status bit is read-only
        if (reg_wr_i) begin
            case (reg_addr_i)
                TSO_ADDR_CTRL:
                    next_r.ctrl = merge(next_r.ctrl, reg_wdata_i,
                                        TSO_CTRL_WMASK);
                TSO_ADDR_CHAN:
                    next_r.chan = reg_wdata_i[2:0];
                TSO_ADDR_WIDE:
                    next_r.wide = merge(r.wide, reg_wdata_i, TSO_WIDE_WMASK);
                TSO_ADDR_COUNT8:
                    next_r.count8 = reg_wdata_i;
                default: ;
            endcase
        end
        next_r.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                TSO_ADDR_CTRL:   next_r.rdata = r.ctrl;
                TSO_ADDR_CHAN:   next_r.rdata = {5'h00, r.chan};
                TSO_ADDR_WIDE:   next_r.rdata = r.wide & TSO_WIDE_WMASK;
                TSO_ADDR_COUNT8: next_r.rdata = r.count8;
                default:         next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o          = r.rdata;
    assign osc_enable_o         = r.osc_en;
    assign current_source_en_o  = r.src_en;
    assign comparator_en_o      = r.cmp_en;
    assign variable_ref_o       = r.vref;
    assign current_level_o      = r.level;
    assign sense_input_pin_sel_o = r.pin_sel;
    assign eight_bit_count_en_o = r.en8;
    assign wide_count_en_o      = r.enw;

    // Enable and range decode
    AST_OFF_WHEN_DISABLED: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !r.ctrl[TSO_BIT_ENABLE] |=>
        !osc_enable_o && sense_input_pin_sel_o == 8'h00)
        else $error("oscillator active while disabled");

    AST_ENABLE_ON: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        osc_runs(r.ctrl[TSO_BIT_ENABLE], r.ctrl[TSO_BIT_REFMODE],
                 r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO]) |=> osc_enable_o)
        else $error("oscillator not started while enabled");

    AST_FIXED_OFF: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.ctrl[TSO_BIT_ENABLE] && !r.ctrl[TSO_BIT_REFMODE] &&
        r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO] == TSO_RANGE_OFF
        |=> !osc_enable_o)
        else $error("fixed mode range zero did not stop oscillator");

    AST_FIXED_RANGE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.ctrl[TSO_BIT_ENABLE] && !r.ctrl[TSO_BIT_REFMODE] &&
        r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO] != TSO_RANGE_OFF
        |=> current_source_en_o &&
        current_level_o == $past(r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO]))
        else $error("fixed mode range not applied");

    AST_NOISE_MODE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.ctrl[TSO_BIT_ENABLE] && r.ctrl[TSO_BIT_REFMODE] &&
        r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO] == TSO_RANGE_OFF
        |=> osc_enable_o && comparator_en_o && !current_source_en_o)
        else $error("noise mode front end wrong");

    AST_RANGE_LEVEL: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.ctrl[TSO_BIT_ENABLE] &&
        r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO] != TSO_RANGE_OFF |=>
        current_level_o == $past(r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO])
        && current_source_en_o)
        else $error("current level does not follow range");

    AST_LEVEL_IDLE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !current_source_en_o |-> current_level_o == TSO_RANGE_OFF)
        else $error("current level set without current source");

    // Front end consistency; only the source drops in noise mode
    AST_CMP_FOLLOWS: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        comparator_en_o == osc_enable_o)
        else $error("comparators out of step with oscillator");

    AST_SRC_NEEDS_OSC: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        current_source_en_o |-> osc_enable_o)
        else $error("current source on with oscillator off");

    AST_VREF: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ##1 variable_ref_o == $past(r.ctrl[TSO_BIT_REFMODE]))
        else $error("reference select mismatch");

    // Channel selection
    AST_CHANNEL: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.ctrl[TSO_BIT_ENABLE] |=> $onehot(sense_input_pin_sel_o))
        else $error("channel select not one-hot");

    AST_CHAN_MAP: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.ctrl[TSO_BIT_ENABLE] |=>
        sense_input_pin_sel_o == (8'h01 << $past(r.chan)))
        else $error("channel select picks wrong input");

    AST_CHAN_READ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == TSO_ADDR_CHAN |=>
        reg_rdata_o == {5'h00, $past(r.chan)})
        else $error("channel register read wrong");

    // Eight-bit timer counting
    AST_T0_SELECT: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        eight_bit_count_en_o |->
        $past(r.ctrl[TSO_BIT_TIMER_ZERO_EXTERNAL_CLOCK_SELECT]) && $past(r.wide[TSO_BIT_W8CS]))
        else $error("8-bit count without oscillator clock select");

    AST_COUNT8_PULSE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        eight_bit_count_en_o |=> !eight_bit_count_en_o)
        else $error("8-bit count pulse longer than one cycle");

    AST_COUNT8_STEP: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        eight_bit_count_en_o &&
        !$past(reg_wr_i && reg_addr_i == TSO_ADDR_COUNT8) |->
        r.count8 == $past(r.count8) + 8'h01)
        else $error("edge counter did not advance");

    AST_SLEEP8: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        sleep_i |=> !eight_bit_count_en_o)
        else $error("8-bit timer counted in sleep");

    // Wide timer counting
    AST_WIDE_OFF: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !r.wide[TSO_BIT_WON] |=> !wide_count_en_o)
        else $error("wide timer counted while off");

    AST_WIDE_GATE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wide_count_en_o |-> wide_from_osc($past(r.wide)) &&
        ($past(wide_gate_i) || !$past(r.wide[TSO_BIT_WGE])))
        else $error("wide count without oscillator source or gate");

    AST_WIDE_FREE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        r.sync2 && !r.sync3 && r.wide[TSO_BIT_WON] &&
        !r.wide[TSO_BIT_WGE] && wide_from_osc(r.wide) |=> wide_count_en_o)
        else $error("free running wide timer missed an edge");

    AST_WIDE_PULSE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wide_count_en_o |=> !wide_count_en_o)
        else $error("wide count pulse longer than one cycle");

    // Sleep leaves the oscillator alone
    AST_SLEEP_OSC: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        sleep_i && osc_runs(r.ctrl[TSO_BIT_ENABLE], r.ctrl[TSO_BIT_REFMODE],
                            r.ctrl[TSO_BIT_RANGE_HI:TSO_BIT_RANGE_LO])
        |=> osc_enable_o)
        else $error("oscillator stopped in sleep");

    // Direction status
    AST_SYNC_DIR: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        osc_enable_o ##1 osc_enable_o |->
        r.ctrl[TSO_BIT_DIR] == $past(r.sync2))
        else $error("direction status not synchronised level");

    AST_DIR_OFF: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !osc_enable_o |-> !r.ctrl[TSO_BIT_DIR])
        else $error("direction status set with oscillator off");

endmodule
`default_nettype wire

// file: inc/tso_pkg.sv
// Constants for the capacitive touch oscillator control block
`default_nettype none
package tso_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] TSO_ADDR_CTRL   = 2'h0;
    localparam logic [1:0] TSO_ADDR_CHAN   = 2'h1;
    localparam logic [1:0] TSO_ADDR_WIDE   = 2'h2;
    localparam logic [1:0] TSO_ADDR_COUNT8 = 2'h3;
    // Control register fields
    localparam int TSO_BIT_ENABLE   = 7;
    localparam int TSO_BIT_REFMODE  = 6;
    localparam int TSO_BIT_RANGE_HI = 3;
    localparam int TSO_BIT_RANGE_LO = 2;
    localparam int TSO_BIT_DIR      = 1;
    localparam int TSO_BIT_TIMER_ZERO_EXTERNAL_CLOCK_SELECT    = 0;
    // Wide timer control fields
    localparam int TSO_BIT_WSRC_HI  = 7;
    localparam int TSO_BIT_WSRC_LO  = 6;
    localparam int TSO_BIT_W8CS     = 2;
    localparam int TSO_BIT_WGE      = 1;
    localparam int TSO_BIT_WON      = 0;
    // Encodings
    localparam logic [1:0] TSO_RANGE_OFF  = 2'h0;
    localparam logic [1:0] TSO_RANGE_LOW  = 2'h1;
    localparam logic [1:0] TSO_RANGE_MED  = 2'h2;
    localparam logic [1:0] TSO_RANGE_HIGH = 2'h3;
    localparam logic [1:0] TSO_WSRC_OSC   = 2'h3;
    localparam logic [7:0] TSO_CTRL_RESET = 8'h00;
    localparam logic [7:0] TSO_CTRL_WMASK = 8'hcd;
    localparam logic [7:0] TSO_CHAN_WMASK = 8'h07;
    localparam logic [7:0] TSO_WIDE_WMASK = 8'hc7;
    // Oscillator drive modes
    typedef enum {
        TSO_OSC_OFF,
        TSO_OSC_NOISE,
        TSO_OSC_LOW,
        TSO_OSC_MED,
        TSO_OSC_HIGH
    } tso_osc_mode_t;
endpackage
`default_nettype wire

// file: testbench/tso_pad_model.sv
// Behavioural electrode pad with its relaxation oscillator
`default_nettype none
module tso_pad_model (
    // Drive from the block and the bench
    input  wire logic run_i,
    input  wire logic hold_i,
    input  wire logic load_i,
    // Oscillator output
    output logic      level_o,
    output int        rises_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Half period 23 ns keeps it slower than a quarter of sys_clk
    // A finger on the pad stretches it to 31 ns
    initial begin
        level_o = 1'b0;
        rises_o = 0;
        forever begin
            #(load_i ? 31 : 23);
            // Swings only while current flows; sleep plays no part
            if (run_i && !hold_i) begin
                level_o = !level_o;
                if (level_o) rises_o++;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/test_tso_ctrl.sv
// Self-checking bench for the touch oscillator control block
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end
module test_tso_ctrl;
    import tso_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, wr, rd, slp, gate, hold, on, src, load;
    logic [1:0]  addr, lvl;
    logic [7:0]  wd, rdat, r, v, psel, got;
    logic        osc, oen, cen, pen, vref, c8, c16;
    int          error_cnt, num_checks, n8, n16, rises, nu, nl, thr;
    logic [31:0] seed;
    logic [17:0] cfg [5];
    tso_ctrl u_dut (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .sleep_i(slp), .wide_gate_i(gate),
        .osc_level_i(osc), .osc_enable_o(oen),
        .current_source_en_o(cen), .comparator_en_o(pen),
        .variable_ref_o(vref), .current_level_o(lvl),
        .sense_input_pin_sel_o(psel), .eight_bit_count_en_o(c8),
        .wide_count_en_o(c16));
    tso_pad_model u_pad (.run_i(oen & cen & pen), .hold_i(hold),
        .load_i(load), .level_o(osc), .rises_o(rises));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic run(input logic [7:0] c, w, input logic s, g);
        int e, x16;
        wreg(TSO_ADDR_CTRL, c);
        wreg(TSO_ADDR_WIDE, w);
        slp <= s;
        // Gate level stands in for the toggle-mode time base
        gate <= g;
        // Counter cleared as the time base opens
        wreg(TSO_ADDR_COUNT8, 8'h00);
        #1 n8 = 0;
        n16 = 0;
        e = rises;
        hold = 1'b0;
        // Time base from a bench loop, not the counting timer
        repeat (200) @(posedge clk);
        #1 hold = 1'b1;
        repeat (8) @(posedge clk);
        #1 e = rises - e;
        `CHK("edges", 1'b1, e > 10)
        `CHK("osc_sleep", 1'b1, oen)
        `CHK("n8", (c[0] & w[2] & !s) ? e : 0, n8)
        x16 = (&w[7:6] & w[0] & (!w[1] | g)) ? e : 0;
        `CHK("n16", x16, n16)
        rreg(TSO_ADDR_COUNT8, r);
        `CHK("count8", n8[7:0], r)
        rreg(TSO_ADDR_CTRL, r);
        `CHK("dir", osc, r[1])
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        if (c8 === 1'b1) n8++;
        if (c16 === 1'b1) n16++;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000 error_cnt++;
        end_of_test();
    end
    initial begin
        {rst, wr, rd, slp, gate, hold, load} = 7'b1000010;
        {addr, wd, error_cnt, num_checks, n8, n16} = '0;
        seed = 32'd12727;
        cfg = '{{8'h8d, 8'h04, 2'b00}, {8'h8d, 8'h04, 2'b10},
            {8'h8c, 8'hc1, 2'b10}, {8'h8c, 8'hc3, 2'b00},
            {8'hcc, 8'hc3, 2'b01}};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 3; a++) begin
            rreg(a[1:0], r);
            `CHK("reset", TSO_CTRL_RESET, r)
        end
        for (int m = 0; m < 16; m++) begin
            v = {m[3], m[2], 2'h0, m[1:0], 2'h0};
            wreg(TSO_ADDR_CTRL, v);
            repeat (2) @(posedge clk);
            #1 on = v[7] && (v[6] || v[3:2] != 2'h0);
            src = on && v[3:2] != 2'h0;
            `CHK("osc_en", on, oen)
            `CHK("cur_en", src, cen)
            `CHK("cmp_en", on, pen)
            `CHK("level", src ? v[3:2] : 2'h0, lvl)
            if (v[7]) `CHK("vref", v[6], vref)
        end
        for (int c = 0; c < 16; c++) begin
            wreg(TSO_ADDR_CTRL, {c[3], 7'h0c});
            wreg(TSO_ADDR_CHAN, {xs() & 8'hf8} | c[2:0]);
            repeat (2) @(posedge clk);
            #1 `CHK("pin_sel", c[3] ? 8'h01 << c[2:0] : 8'h00, psel)
        end
        for (int i = 0; i < 24; i++) begin
            r = xs();
            wreg(i % 3, r);
            v = (i % 3 == 0) ? (TSO_CTRL_WMASK & 8'hfd) :
                (i % 3 == 1) ? TSO_CHAN_WMASK : TSO_WIDE_WMASK;
            rreg(i % 3, got);
            // Status bit is live, not a stored value
            if (i % 3 == 0) got[TSO_BIT_DIR] = 1'b0;
            `CHK("readback", r & v, got)
        end
        foreach (cfg[k]) begin
            run(cfg[k][17:10], cfg[k][9:2], cfg[k][1], cfg[k][0]);
        end
        for (int i = 0; i < 8; i++) begin
            run(8'h8c | (xs() & 8'h41), xs(), xs() > 8'h80, xs() > 8'h80);
        end
        // Unloaded then loaded pad over the same bench time base
        run(8'h8d, 8'hc5, 1'b0, 1'b0);
        nu = n16;
        load = 1'b1;
        run(8'h8d, 8'hc5, 1'b0, 1'b0);
        nl = n16;
        load = 1'b0;
        thr = (nu + nl) / 2;
        `CHK("touch", 1'b1, nl < thr && thr < nu)
        end_of_test();
    end
endmodule
`default_nettype wire
